// ---- src/see_device.sv ----
// Purpose: eeprom device end: decodes instructions, holds the array
// Assumes: link pins are asynchronous, synchronised here on clk
// Notes: org16 chooses 64x16, otherwise 128x8
`timescale 1ns/1ps
`default_nettype none
// Function
// - data out only during read
// - read decodes, loads word into shifter
// - zero dummy bit precedes read data
// - output changes while serial clock high
// - program carries 8/16 data, 7/6 address
// - after last bit, erase then write
// - busy low during program cycle
// - program cycle self-timed internally
// - all-ones program erases one word
// - unlock once; stays until lock
// - read works locked or unlocked
// - bulk erase sets all bits
// - bulk write: zero address, one word
// - busy low during bulk write
module see_device
    import see_pkg::*;
#(
    parameter int PROG_CYCLES = SEE_PROG_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic org16,
    see_link_if.device link
);
    typedef enum logic [2:0] {IDLE, HEAD, DATA, RDOUT, BUSY, DONE} see_state_e;
    // ==========================================================
    // synchronisers
    logic [1:0] csSync, skSync, diSync;
    logic skLast;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            csSync <= 2'h0;
            skSync <= 2'h0;
            diSync <= 2'h0;
            skLast <= 1'b0;
        end else begin
            csSync <= {csSync[0], link.chipSelect};
            skSync <= {skSync[0], link.serialClock};
            diSync <= {diSync[0], link.serialIn};
            skLast <= skSync[1];
        end
    end
    wire logic cs = csSync[1];
    wire logic skRise = skSync[1] & ~skLast;
    wire logic di = diSync[1];
    // ==========================================================
    // state and array
    logic [SEE_MAX_DATA_W-1:0] mem [SEE_DEPTH];
    see_state_e state, next_state;
    logic [4:0] cnt, next_cnt;
    logic [10:0] head, next_head;
    logic [SEE_MAX_DATA_W:0] shift, next_shift;
    logic unlocked, next_unlocked;
    logic ready, next_ready;
    logic dout, next_dout;
    logic [31:0] timer, next_timer;
    logic writeAll, next_writeAll;
    logic memWe;
    logic [SEE_MAX_ADDR_W-1:0] memAddr;
    logic [SEE_MAX_DATA_W-1:0] memData;
    logic [4:0] aw, dw;
    logic [3:0] opc;
    logic [SEE_MAX_ADDR_W-1:0] addr;
    always_comb begin
        aw = org16 ? 5'(SEE_ADDR_W16) : 5'(SEE_ADDR_W8);
        dw = org16 ? 5'(SEE_MAX_DATA_W) : 5'(SEE_MAX_DATA_W / 2);
        opc = org16 ? head[9:6] : head[10:7];
        addr = org16 ? {1'b0, head[5:0]} : head[6:0];
    end
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_head = head;
        next_shift = shift;
        next_unlocked = unlocked;
        next_ready = ready;
        next_dout = dout;
        next_timer = timer;
        next_writeAll = writeAll;
        memWe = 1'b0;
        memAddr = addr;
        memData = shift[SEE_MAX_DATA_W-1:0];
        unique case (state)
            IDLE: begin
                next_dout = 1'b0;
                if (cs && skRise && di) begin
                    next_state = HEAD;
                    next_cnt = 5'h0;
                    next_head = 11'h0;
                end
            end
            HEAD: if (!cs) begin
                next_state = IDLE;
            end else if (skRise) begin
                next_head = {head[9:0], di};
                next_cnt = cnt + 5'h1;
                if (cnt == aw + 5'(SEE_OPC_W) - 5'h1) begin
                    next_cnt = 5'h0;
                    next_state = DONE;
                    next_writeAll = 1'b0;
                    if ((org16 ? head[8:7] : head[9:8]) == 2'h2) begin
                        // read is never gated by lock state
                        next_shift = {1'b0, mem[org16 ? {1'b0, next_head[5:0]}
                                                      : next_head[6:0]]};
                        if (!org16) next_shift = {1'b0, next_shift[7:0], 8'h00};
                        next_state = RDOUT;
                    end else if ((org16 ? head[8:7] : head[9:8]) == 2'h1
                                 || (org16 ? next_head[9:6] : next_head[10:7])
                                    == SEE_OP_BWRITE) begin
                        next_state = DATA;
                    end
                end
            end
            DATA: if (!cs) begin
                next_state = IDLE;
            end else if (skRise) begin
                next_shift = {shift[SEE_MAX_DATA_W-1:0], di};
                next_cnt = cnt + 5'h1;
                if (cnt == dw - 5'h1) next_state = DONE;
            end
            RDOUT: begin
                // shifter loaded on rise; bit changes while clock is high
                if (!cs) begin
                    next_state = IDLE;
                    next_dout = 1'b0;
                end else if (skRise) begin
                    next_dout = shift[SEE_MAX_DATA_W];
                    next_shift = {shift[SEE_MAX_DATA_W-1:0], 1'b0};
                end
            end
            DONE: if (!cs) begin
                next_state = IDLE;
                unique case (opc)
                    SEE_OP_UNLOCK: next_unlocked = 1'b1;
                    SEE_OP_LOCK: next_unlocked = 1'b0;
                    default: begin
                        if (unlocked && (opc[3:2] == 2'h1 || opc == SEE_OP_BERASE
                                         || opc == SEE_OP_BWRITE)) begin
                            next_state = BUSY;
                            next_ready = 1'b0;
                            next_timer = 32'h0;
                            next_cnt = 5'h0;
                            if (opc == SEE_OP_BERASE) next_shift = 17'h1FFFF;
                            if (!org16) next_shift[15:8] = 8'h00;
                            next_writeAll = opc[3:2] == 2'h0;
                        end
                    end
                endcase
            end
            BUSY: begin
                // erase step then write step, both timed here
                next_timer = timer + 32'h1;
                if (timer == 32'(PROG_CYCLES / 2)) begin
                    memData = {SEE_MAX_DATA_W{1'b1}};
                    memWe = 1'b1;
                end else if (timer == 32'(PROG_CYCLES - 1)) begin
                    memWe = 1'b1;
                    next_ready = 1'b1;
                    next_state = IDLE;
                end
            end
            default: next_state = IDLE;
        endcase
    end
    // ==========================================================
    // registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= IDLE;
            cnt <= 5'h0;
            head <= 11'h0;
            shift <= 17'h0;
            unlocked <= 1'b0;
            ready <= 1'b1;
            dout <= 1'b0;
            timer <= 32'h0;
            writeAll <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            head <= next_head;
            shift <= next_shift;
            unlocked <= next_unlocked;
            ready <= next_ready;
            dout <= next_dout;
            timer <= next_timer;
            writeAll <= next_writeAll;
        end
    end
    always_ff @(posedge clk) begin
        if (memWe) begin
            for (int i = 0; i < SEE_DEPTH; i++) begin
                if (writeAll || i[6:0] == memAddr) mem[i] <= memData;
            end
        end
    end
    assign link.serialOut = dout;
    assign link.readyBusy = ready;
endmodule
`default_nettype wire

// ---- src/see_pkg.sv ----
// Purpose: shared constants for the serial eeprom instruction engine
// Assumes: one system clock at 25 MHz; serial link made by the host end
// Notes: instruction frame is start bit, 4-bit opcode, address, optional data
package see_pkg;
    // ==========================================================
    // organization and frame
    localparam int SEE_ADDR_W8 = 7;
    localparam int SEE_ADDR_W16 = 6;
    localparam int SEE_OPC_W = 4;
    localparam int SEE_MAX_ADDR_W = 7;
    localparam int SEE_MAX_DATA_W = 16;
    localparam int SEE_DEPTH = 128;
    // ==========================================================
    // opcodes
    localparam logic [3:0] SEE_OP_UNLOCK = 4'h3;
    localparam logic [3:0] SEE_OP_LOCK = 4'h0;
    localparam logic [3:0] SEE_OP_BERASE = 4'h2;
    localparam logic [3:0] SEE_OP_BWRITE = 4'h1;
    localparam logic [3:0] SEE_OP_READ = 4'h8;
    localparam logic [3:0] SEE_OP_PROG = 4'h4;
    // ==========================================================
    // timing
    localparam int SEE_CLK_HZ = 25000000;
    localparam int SEE_PROG_TIME_MS = 10;
    localparam int SEE_PROG_CYCLES = SEE_CLK_HZ / 1000 * SEE_PROG_TIME_MS;
    localparam int SEE_SCLK_HZ = 250000;
    localparam int SEE_HALF_CYCLES = SEE_CLK_HZ / SEE_SCLK_HZ / 2;
    // busy low needs this long to cross both synchronisers after select drops
    localparam int SEE_GAP_CYCLES = 8;
    typedef enum logic [2:0] {
        SEE_CMD_READ,
        SEE_CMD_PROG,
        SEE_CMD_UNLOCK,
        SEE_CMD_LOCK,
        SEE_CMD_BERASE,
        SEE_CMD_BWRITE
    } see_cmd_e;
endpackage

// ---- src/see_link_if.sv ----
// Purpose: serial link between the eeprom device and its controller
// Assumes: chip select, serial clock and data in made by host
// Notes: one modport per end
`timescale 1ns/1ps
`default_nettype none
interface see_link_if;
    logic chipSelect;
    logic serialClock;
    logic serialIn;
    logic serialOut;
    logic readyBusy;
    modport device (input chipSelect, input serialClock, input serialIn,
                    output serialOut, output readyBusy);
    modport host (output chipSelect, output serialClock, output serialIn,
                  input serialOut, input readyBusy);
endinterface
`default_nettype wire

// ---- src/see_host.sv ----
// Purpose: controller end: frames one instruction per request
// Assumes: serial clock divided from clk
// Notes: waits for ready high before starting
`timescale 1ns/1ps
`default_nettype none
module see_host
    import see_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic org16,
    input wire logic reqValid,
    input wire see_cmd_e reqCmd,
    input wire logic [SEE_MAX_ADDR_W-1:0] reqAddr,
    input wire logic [SEE_MAX_DATA_W-1:0] reqData,
    output logic reqReady,
    output logic rspValid,
    output logic [SEE_MAX_DATA_W-1:0] rspData,
    see_link_if.host link
);
    typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP} see_hstate_e;
    see_hstate_e state, next_state;
    logic [1:0] rdySync, doSync;
    logic [39:0] frame, next_frame;
    logic [5:0] bits, next_bits;
    logic [7:0] div, next_div;
    logic sk, next_sk, cs, next_cs, isRead, next_isRead;
    logic [SEE_MAX_DATA_W:0] rx, next_rx;
    logic next_rspValid;
    logic [SEE_MAX_DATA_W-1:0] next_rspData;
    logic [5:0] aw, dw;
    logic [3:0] opc;
    logic [SEE_MAX_ADDR_W-1:0] a;
    always_comb begin
        aw = org16 ? 6'(SEE_ADDR_W16) : 6'(SEE_ADDR_W8);
        dw = org16 ? 6'(SEE_MAX_DATA_W) : 6'(SEE_MAX_DATA_W / 2);
        a = reqAddr;
        unique case (reqCmd)
            SEE_CMD_READ: opc = SEE_OP_READ;
            SEE_CMD_PROG: opc = SEE_OP_PROG;
            SEE_CMD_UNLOCK: opc = SEE_OP_UNLOCK;
            SEE_CMD_LOCK: opc = SEE_OP_LOCK;
            SEE_CMD_BERASE: opc = SEE_OP_BERASE;
            default: opc = SEE_OP_BWRITE;
        endcase
        // opcode carries the whole command; address field stays zero
        if (reqCmd inside {SEE_CMD_UNLOCK, SEE_CMD_LOCK, SEE_CMD_BERASE, SEE_CMD_BWRITE}) begin
            a = 7'h00;
        end
    end
    always_comb begin
        next_state = state;
        next_frame = frame;
        next_bits = bits;
        next_div = div;
        next_sk = sk;
        next_cs = cs;
        next_isRead = isRead;
        next_rx = rx;
        next_rspValid = 1'b0;
        next_rspData = rspData;
        unique case (state)
            H_IDLE: if (reqValid && rdySync[1]) begin
                next_state = H_SHIFT;
                next_cs = 1'b1;
                next_isRead = reqCmd == SEE_CMD_READ;
                next_frame = {1'b1, opc, (org16 ? {a[5:0], 1'b0} : a),
                              (org16 ? reqData : {reqData[7:0], 8'h00}), 12'h000};
                if (!(reqCmd inside {SEE_CMD_PROG, SEE_CMD_BWRITE})) begin
                    next_frame[27:12] = 16'h0000;
                end
                next_bits = 6'(1 + SEE_OPC_W) + aw
                            + ((reqCmd inside {SEE_CMD_PROG, SEE_CMD_BWRITE})
                            ? dw : (next_isRead ? dw + 6'h1 : 6'h0));
                // x16 address is one bit shorter: drop its pad bit
                if (org16) next_frame = {next_frame[39:29], next_frame[27:0], 1'b0};
                next_div = 8'h0;
            end
            H_SHIFT: begin
                next_div = div + 8'h1;
                if (div == 8'(SEE_HALF_CYCLES - 1)) begin
                    next_div = 8'h0;
                    next_sk = ~sk;
                    if (sk) begin
                        // sample on falling edge, away from the change
                        next_rx = {rx[SEE_MAX_DATA_W-1:0], doSync[1]};
                        next_frame = {frame[38:0], 1'b0};
                        next_bits = bits - 6'h1;
                        if (bits == 6'h1) next_state = H_GAP;
                    end
                end
            end
            H_GAP: begin
                // no new request until a busy low has crossed both synchronisers
                next_cs = 1'b0;
                next_div = div + 8'h1;
                if (div == 8'(SEE_GAP_CYCLES - 1)) begin
                    next_state = H_IDLE;
                    if (isRead) begin
                        next_rspValid = 1'b1;
                        next_rspData = org16 ? rx[15:0] : {8'h00, rx[7:0]};
                    end
                end
            end
            default: next_state = H_IDLE;
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdySync <= 2'h0;
            doSync <= 2'h0;
            state <= H_IDLE;
            frame <= 40'h0;
            bits <= 6'h0;
            div <= 8'h0;
            sk <= 1'b0;
            cs <= 1'b0;
            isRead <= 1'b0;
            rx <= 17'h0;
            rspValid <= 1'b0;
            rspData <= 16'h0;
            reqReady <= 1'b0;
        end else begin
            rdySync <= {rdySync[0], link.readyBusy};
            doSync <= {doSync[0], link.serialOut};
            state <= next_state;
            frame <= next_frame;
            bits <= next_bits;
            div <= next_div;
            sk <= next_sk;
            cs <= next_cs;
            isRead <= next_isRead;
            rx <= next_rx;
            rspValid <= next_rspValid;
            rspData <= next_rspData;
            reqReady <= next_state == H_IDLE && rdySync[1];
        end
    end
    assign link.chipSelect = cs;
    assign link.serialClock = sk;
    assign link.serialIn = frame[39];
endmodule
`default_nettype wire

// ---- bench/see_link_asserts.sv ----
// Purpose: concurrent checks on the link between device end and host end
// Assumes: PROG_CYCLES equals the value given to the device
// Notes: header decode looks only at the four opcode bits
`timescale 1ns/1ps
`default_nettype none
module see_link_asserts #(
    parameter int PROG_CYCLES = 200
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic chipSelect,
    input wire logic serialClock,
    input wire logic serialIn,
    input wire logic serialOut,
    input wire logic readyBusy
);
    localparam int BUSY_SPAN = PROG_CYCLES + 8;
    // ==========================================================
    // frame header tracking
    logic skPrev;
    logic csPrev;
    logic [5:0] bitCnt;
    logic [1:0] op;
    logic [1:0] top;
    logic unlocked;
    logic [15:0] lowCnt;
    logic writeOp;
    assign writeOp = (op == 2'b01) || (op == 2'b00 && top[0] != top[1]);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            skPrev <= 1'b0;
            csPrev <= 1'b0;
            bitCnt <= 6'h00;
            op <= 2'h0;
            top <= 2'h0;
            unlocked <= 1'b0;
            lowCnt <= 16'h0000;
        end else begin
            skPrev <= serialClock;
            csPrev <= chipSelect;
            lowCnt <= readyBusy ? 16'h0000 : lowCnt + 16'h0001;
            if (!chipSelect) begin
                bitCnt <= 6'h00;
            end else if (serialClock && !skPrev) begin
                bitCnt <= (bitCnt == 6'h3F) ? bitCnt : bitCnt + 6'h01;
                if (bitCnt == 6'h01 || bitCnt == 6'h02) begin
                    op <= {op[0], serialIn};
                end
                if (bitCnt == 6'h03 || bitCnt == 6'h04) begin
                    top <= {top[0], serialIn};
                end
            end
            // lock state follows completed lock and unlock frames only
            if (csPrev && !chipSelect && op == 2'b00 && top[0] == top[1]) begin
                unlocked <= top[0];
            end
        end
    end
    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_out_on_high: assert property (
        chipSelect && bitCnt > 6'h03 && $changed(serialOut) |-> serialClock)
        else $error("serial out moved while serial clock low");
    a_out_read_only: assert property (
        chipSelect && bitCnt > 6'h02 && op != 2'b10 |-> $stable(serialOut))
        else $error("serial out moved outside a read");
    a_write_goes_busy: assert property (
        $fell(chipSelect) && writeOp && unlocked |-> ##[1:12] !readyBusy)
        else $error("write frame did not start a busy period");
    a_busy_needs_unlock: assert property (
        $fell(readyBusy) |-> unlocked && writeOp && !chipSelect)
        else $error("busy without an unlocked write frame");
    a_busy_ends: assert property (
        $fell(readyBusy) |-> ##[1:BUSY_SPAN] $rose(readyBusy))
        else $error("busy period did not end in time");
    a_busy_length: assert property (
        $rose(readyBusy) |-> lowCnt >= PROG_CYCLES - 1 && lowCnt <= PROG_CYCLES + 1)
        else $error("busy period length wrong");
    a_start_when_ready: assert property (
        $rose(chipSelect) |-> readyBusy)
        else $error("frame started while device busy");
    a_busy_no_frame: assert property (
        !readyBusy |-> !chipSelect)
        else $error("host selected device during busy");
endmodule
`default_nettype wire

// ---- bench/serial_eeprom_instruction_engine_tb_top.sv ----
// Purpose: end-to-end bench, host end drives device end over the link
// Assumes: PROG_CYCLES shortened so busy periods stay brief
// Notes: table rows first, then a reset in mid-busy
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_instruction_engine_tb_top
    import see_pkg::*;
();
    localparam int PROG_CYCLES = 200;
    typedef struct {
        logic org;
        see_cmd_e cmd;
        logic [6:0] addr;
        logic [15:0] data;
        logic busy;
        logic [15:0] rd;
    } see_row_s;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic org16 = 1'b0;
    logic reqValid = 1'b0;
    see_cmd_e reqCmd = SEE_CMD_READ;
    logic [6:0] reqAddr = 7'h00;
    logic [15:0] reqData = 16'h0000;
    logic reqReady;
    logic rspValid;
    logic [15:0] rspData;
    int failures = 0;
    int check_count = 0;
    logic [31:0] outBits = 32'h00000000;
    logic [15:0] skRises = 16'h0000;
    logic [15:0] frameLen = 16'h0000;
    // ==========================================================
    // rows: org, command, address, data, busy expected, read value
    see_row_s rows [22] = '{
        '{1'b0, SEE_CMD_UNLOCK, 7'h00, 16'h0000, 1'b0, 16'h0000},
        '{1'b0, SEE_CMD_BERASE, 7'h00, 16'h0000, 1'b1, 16'h0000},
        '{1'b0, SEE_CMD_READ, 7'h05, 16'h0000, 1'b0, 16'h00FF},
        '{1'b0, SEE_CMD_PROG, 7'h05, 16'h003C, 1'b1, 16'h0000},
        '{1'b0, SEE_CMD_PROG, 7'h7F, 16'h00A5, 1'b1, 16'h0000},
        '{1'b0, SEE_CMD_READ, 7'h05, 16'h0000, 1'b0, 16'h003C},
        '{1'b0, SEE_CMD_READ, 7'h7F, 16'h0000, 1'b0, 16'h00A5},
        '{1'b0, SEE_CMD_PROG, 7'h05, 16'h00FF, 1'b1, 16'h0000},
        '{1'b0, SEE_CMD_READ, 7'h05, 16'h0000, 1'b0, 16'h00FF},
        '{1'b0, SEE_CMD_LOCK, 7'h00, 16'h0000, 1'b0, 16'h0000},
        '{1'b0, SEE_CMD_PROG, 7'h7F, 16'h0000, 1'b0, 16'h0000},
        '{1'b0, SEE_CMD_BWRITE, 7'h00, 16'h0011, 1'b0, 16'h0000},
        '{1'b0, SEE_CMD_BERASE, 7'h00, 16'h0000, 1'b0, 16'h0000},
        '{1'b0, SEE_CMD_READ, 7'h7F, 16'h0000, 1'b0, 16'h00A5},
        '{1'b0, SEE_CMD_UNLOCK, 7'h00, 16'h0000, 1'b0, 16'h0000},
        '{1'b0, SEE_CMD_BWRITE, 7'h00, 16'h005A, 1'b1, 16'h0000},
        '{1'b0, SEE_CMD_READ, 7'h7F, 16'h0000, 1'b0, 16'h005A},
        '{1'b1, SEE_CMD_PROG, 7'h3F, 16'h8001, 1'b1, 16'h0000},
        '{1'b1, SEE_CMD_READ, 7'h3F, 16'h0000, 1'b0, 16'h8001},
        '{1'b1, SEE_CMD_BWRITE, 7'h00, 16'hC3E1, 1'b1, 16'h0000},
        '{1'b1, SEE_CMD_READ, 7'h21, 16'h0000, 1'b0, 16'hC3E1},
        '{1'b1, SEE_CMD_BERASE, 7'h00, 16'h0000, 1'b1, 16'h0000}
    };
    see_link_if link ();
    see_device #(.PROG_CYCLES(PROG_CYCLES)) u_see_device (.clk(clk), .rst_n(rst_n),
        .org16(org16), .link(link));
    see_host u_see_host (.clk(clk), .rst_n(rst_n), .org16(org16), .reqValid(reqValid),
        .reqCmd(reqCmd), .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady),
        .rspValid(rspValid), .rspData(rspData), .link(link));
    see_link_asserts #(.PROG_CYCLES(PROG_CYCLES)) u_see_link_asserts (.clk(clk),
        .rst_n(rst_n), .chipSelect(link.chipSelect), .serialClock(link.serialClock),
        .serialIn(link.serialIn), .serialOut(link.serialOut), .readyBusy(link.readyBusy));
    initial begin
        forever #20 clk = ~clk;
    end
    // ==========================================================
    // wire monitors: output sampled on the serial clock falling edge, away from the change
    always @(negedge link.serialClock) begin
        if (link.chipSelect) begin
            outBits <= {outBits[30:0], link.serialOut};
        end
    end
    // one process owns the count: select rise clears, clock rise counts
    always @(posedge link.serialClock or posedge link.chipSelect) begin
        skRises <= link.serialClock ? skRises + 16'h0001 : 16'h0000;
    end
    always @(negedge link.chipSelect) frameLen <= skRises;
    // ==========================================================
    // tasks
    task automatic check_bit(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check_word(input string what, input logic [15:0] exp,
                              input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // request held until the edge that sees reqReady high
    task automatic send(input see_row_s r);
        @(posedge clk);
        org16 <= r.org;
        @(posedge clk);
        reqValid <= 1'b1;
        reqCmd <= r.cmd;
        reqAddr <= r.addr;
        reqData <= r.data;
        @(negedge clk);
        for (int n = 0; n < 20000 && reqReady !== 1'b1; n++) @(negedge clk);
        check_bit("request taken", 1'b1, reqReady);
        @(posedge clk);
        reqValid <= 1'b0;
    endtask
    task automatic run(input see_row_s r);
        logic busySeen;
        logic [15:0] got;
        logic [15:0] mask;
        busySeen = 1'b0;
        got = 16'h0000;
        mask = r.org ? 16'hFFFF : 16'h00FF;
        send(r);
        // second pass catches busy that shows after ready briefly returns
        repeat (2) for (int n = 0; n < 20000 && (n < 12 || reqReady !== 1'b1); n++) begin
            @(negedge clk);
            busySeen |= (link.readyBusy === 1'b0);
            if (rspValid === 1'b1) got = rspData;
        end
        check_bit("busy seen", r.busy, busySeen);
        if (r.cmd == SEE_CMD_READ) begin
            check_word("read data", r.rd & mask, got & mask);
            check_bit("dummy bit", 1'b0, outBits[r.org ? 16 : 8]);
            check_word("wire data", r.rd & mask, outBits[15:0] & mask);
        end else if (r.cmd inside {SEE_CMD_PROG, SEE_CMD_BWRITE}) begin
            // start, four opcode bits, address, data word
            check_word("frame bits", r.org ? 16'h001B : 16'h0014, frameLen);
        end else begin
            check_word("frame bits", r.org ? 16'h000B : 16'h000C, frameLen);
        end
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) run(rows[i]);
        // reset while a program cycle is running
        run('{1'b1, SEE_CMD_UNLOCK, 7'h00, 16'h0000, 1'b0, 16'h0000});
        send('{1'b1, SEE_CMD_PROG, 7'h10, 16'h1234, 1'b1, 16'h0000});
        for (int n = 0; n < 20000 && link.readyBusy !== 1'b0; n++) @(negedge clk);
        repeat (5) @(posedge clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        check_bit("busy in reset", 1'b1, link.readyBusy);
        check_bit("select in reset", 1'b0, link.chipSelect);
        check_bit("ready in reset", 1'b0, reqReady);
        @(posedge clk);
        rst_n <= 1'b1;
        // device comes out of reset locked
        run('{1'b1, SEE_CMD_PROG, 7'h21, 16'h0000, 1'b0, 16'h0000});
        run('{1'b1, SEE_CMD_READ, 7'h21, 16'h0000, 1'b0, 16'hFFFF});
        stop_test();
    end
    initial begin
        // about 55000 cycles of frames and busy periods, with margin
        repeat (90000) @(posedge clk);
        failures++;
        stop_test();
    end
endmodule
`default_nettype wire
